// ---- logic/rtpo_timer.sv ----
// reload timer with pulse output on a selectable pin
// assumes a register port on clk; onchip_osc_clock and subclock_div32
// arrive as asynchronous levels and are synchronised here
// the pins are driven through outside pads: the Oe outputs
// enable the pad drivers, and the In inputs are raw pad levels
// the port inputs carry ordinary port drive while the timer
// does not own a pin
// register map, one byte each on the 3-bit port
//   0 control: b0 start, b1 force stop (write only), b2 active
//   1 pin control: b0 start level, b1 output off,
//     b2 inverse enable, b3 pin select
//   2 mode: b0 pulse mode; any write reloads the start level
//   3 prescaler count, 4 main count, 5 count source
//   6 and 7 are unmapped: ignored on write, zero on read
//
// count sources
//   0 every clk, 1 every second clk, 2 every eighth clk
//   3 rising edge of onchip_osc_clock, 4 of subclock_div32
//
// timing
//   a write lands on the edge that samples its strobe
//   read data stand only in the cycle after the read strobe
//   the interrupt pulse lasts one cycle, right after underflow
//   the pin level changes in that same cycle
//   one underflow every (n+1)(m+1) count events
//
// hazards and limits
//   a write while running only marks the stage; the counter
//   takes the reload at that stage's next count event, and a
//   count event that meets the write is spent by the write
//   divided sources restart from zero after every stop, so
//   the first divided period after a start is exact
//   slow sources are sampled, so each of their phases must
//   last more than one clk cycle or edges are lost
//   the inverse pin ignores the output off bit on purpose
//   a mode write in the cycle of an underflow wins over the
//   toggle, so the pin always starts at the chosen level
//   with clkEn low nothing moves, the slow source edges
//   included; such edges may then be missed
//   an unmapped write is dropped without any side effect
//   reads have no side effect either
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "rtpo_map.svh"
module rtpo_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    input wire logic onchipOscClock,
    input wire logic subclockDiv32,
    input wire logic portOutA,
    input wire logic portOutB,
    input wire logic portOeA,
    input wire logic portOeB,
    input wire logic pinAIn,
    input wire logic pinBIn,
    output logic pinAOut,
    output logic pinAOe,
    output logic pinBOut,
    output logic pinBOe,
    input wire logic invPortOut,
    input wire logic invPortOe,
    output logic invertedOutPin,
    output logic invertedOutOe,
    output logic extIrq1Input,
    output logic timerIrq
);
    ////////////////////////////////////////////////////////////////////
    // state
    // everything the block remembers outside the two stages lives in one struct
    typedef struct packed {
        // slow source synchronisers and edge memory
        logic [1:0] oscSync;
        logic [1:0] subSync;
        logic oscLast;
        logic subLast;

        // clk divider for the divided sources, and run flag
        logic [2:0] div;
        logic running;

        // configuration written by software
        logic pulseMode;
        logic [2:0] srcSel;
        logic pol;
        logic outOff;
        logic invEn;
        logic pinSel;

        // current pulse level
        logic level;

        // pin input synchronisers
        logic [1:0] pinASync;
        logic [1:0] pinBSync;

        // registered read data and interrupt pulse
        logic [7:0] rdData;
        logic irq;
    } rtpo_timer_s;
    rtpo_timer_s st;
    rtpo_timer_s next_st;

    // write decodes of the two count registers
    logic wrPresc;
    logic wrMain;

    // one-cycle count event of the selected source
    logic srcEvt;

    // stage underflows, each one cycle wide
    logic presUf;
    logic mainUf;

    // live counter contents for the read path
    logic [WIDTH-1:0] presCount;
    logic [WIDTH-1:0] mainCount;

    // decode of a write strobe for one offset
    // used for both count registers
    function automatic logic hitWr(input logic [2:0] a,
                                   input logic [2:0] off,
                                   input logic stb);
        hitWr = stb && (a == off);
    endfunction : hitWr

    assign wrPresc = hitWr(addr, `RTPO_OFF_PRESC, wrStb);
    assign wrMain = hitWr(addr, `RTPO_OFF_MAIN, wrStb);

    ////////////////////////////////////////////////////////////////////
    // count source select
    // a code outside the table stops the count quietly
    always_comb begin
        case (rtpo_pkg::rtpo_src_e'(st.srcSel))
            // every clk
            rtpo_pkg::RTPO_SRC_F1: srcEvt = 1'b1;
            // every second clk, the divider low bit
            rtpo_pkg::RTPO_SRC_F2: srcEvt = st.div[0] == 1'b1;
            // every eighth clk, the divider wrapping
            rtpo_pkg::RTPO_SRC_F8: srcEvt = st.div == 3'h7;
            // rising edges of the slow sources, after the sync
            rtpo_pkg::RTPO_SRC_OSC: srcEvt = st.oscSync[1] && !st.oscLast;
            rtpo_pkg::RTPO_SRC_SUB: srcEvt = st.subSync[1] && !st.subLast;
            // codes 5 to 7 never count
            default: srcEvt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // the two stages
    // the prescaler counts source events; the main stage counts
    // prescaler underflows, so its reload lines up with them
    // both take the full write byte only when WIDTH is 8
    // prescaler
    rtpo_stage #(.WIDTH(WIDTH)) uPresc (
        .clk(clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .wrEn(wrPresc),
        .wrData(wrData[WIDTH-1:0]),
        .countEvt(srcEvt),
        .running(st.running),
        .count(presCount),
        .underflow(presUf)
    );

    // main timer
    rtpo_stage #(.WIDTH(WIDTH)) uMain (
        .clk(clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .wrEn(wrMain),
        .wrData(wrData[WIDTH-1:0]),
        .countEvt(presUf),
        .running(st.running),
        .count(mainCount),
        .underflow(mainUf)
    );

    ////////////////////////////////////////////////////////////////////
    // control, output level and read path
    always_comb begin
        next_st = st;

        // two-stage synchronisers; only the second stage is read
        next_st.oscSync = {st.oscSync[0], onchipOscClock};
        next_st.subSync = {st.subSync[0], subclockDiv32};
        next_st.oscLast = st.oscSync[1];
        next_st.subLast = st.subSync[1];
        next_st.pinASync = {st.pinASync[0], pinAIn};
        next_st.pinBSync = {st.pinBSync[0], pinBIn};

        // divider runs only while counting, so it restarts clean
        next_st.div = st.running ? st.div + 3'h1 : 3'h0;

        // interrupt pulse follows the main underflow by one cycle
        next_st.irq = mainUf;

        // pulse level flips on each main underflow in pulse mode
        // the new level shows in the same cycle as the irq pulse
        if (mainUf && st.pulseMode) begin
            next_st.level = !st.level;
        end

        // register writes come last so they win over the toggle
        if (wrStb) begin
            case (addr)
                // control: force stop beats start
                `RTPO_OFF_CTRL: begin
                    if (wrData[`RTPO_CTRL_STOP]) begin
                        next_st.running = 1'b0;
                    end else begin
                        next_st.running = wrData[`RTPO_CTRL_START];
                    end
                end

                // pin control
                `RTPO_OFF_PINCTL: begin
                    next_st.pol = wrData[`RTPO_PIN_POL];
                    next_st.outOff = wrData[`RTPO_PIN_OFF];
                    next_st.invEn = wrData[`RTPO_PIN_INVEN];
                    next_st.pinSel = wrData[`RTPO_PIN_SEL];
                end

                // mode: the start level is reloaded on every write
                `RTPO_OFF_MODE: begin
                    next_st.pulseMode = wrData[`RTPO_MODE_PULSE];
                    next_st.level = st.pol;
                end

                // count source code
                `RTPO_OFF_SRC: next_st.srcSel = wrData[2:0];

                // count registers are handled in the stages
                default: ;
            endcase
        end

        // read data: zero unless a read strobe selects a register
        next_st.rdData = `RTPO_RST_BYTE;
        if (rdStb) begin
            case (addr)
                // control: start and active both show the run flag
                `RTPO_OFF_CTRL: begin
                    next_st.rdData[`RTPO_CTRL_START] = st.running;
                    next_st.rdData[`RTPO_CTRL_ACTIVE] = st.running;
                end

                // pin control
                `RTPO_OFF_PINCTL: begin
                    next_st.rdData[`RTPO_PIN_POL] = st.pol;
                    next_st.rdData[`RTPO_PIN_OFF] = st.outOff;
                    next_st.rdData[`RTPO_PIN_INVEN] = st.invEn;
                    next_st.rdData[`RTPO_PIN_SEL] = st.pinSel;
                end

                // mode
                `RTPO_OFF_MODE: begin
                    next_st.rdData[`RTPO_MODE_PULSE] = st.pulseMode;
                end

                // prescaler live count, not the reload value
                `RTPO_OFF_PRESC: begin
                    next_st.rdData[WIDTH-1:0] = presCount;
                end

                // main live count, not the reload value
                `RTPO_OFF_MAIN: begin
                    next_st.rdData[WIDTH-1:0] = mainCount;
                end

                // count source code
                `RTPO_OFF_SRC: next_st.rdData[2:0] = st.srcSel;

                // unmapped reads give zero
                default: next_st.rdData = `RTPO_RST_BYTE;
            endcase
        end
    end

    // state register
    // clkEn low holds every field, the synchronisers included
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin routing
    // the timer owns pin A or B only in pulse mode with output on
    logic pulseDrive;
    assign pulseDrive = st.pulseMode && !st.outOff;

    // selected pin carries the pulse, the other stays a port
    assign pinAOut = (pulseDrive && !st.pinSel) ? st.level : portOutA;
    assign pinAOe = (pulseDrive && !st.pinSel) ? 1'b1 : portOeA;
    assign pinBOut = (pulseDrive && st.pinSel) ? st.level : portOutB;
    assign pinBOe = (pulseDrive && st.pinSel) ? 1'b1 : portOeB;

    // complement pin tracks the internal level even with output off
    assign invertedOutPin = (st.pulseMode && st.invEn) ?
        !st.level : invPortOut;
    // port drive returns as soon as the inverse is disabled
    assign invertedOutOe = (st.pulseMode && st.invEn) ? 1'b1 : invPortOe;

    // interrupt input from whichever pin is selected
    assign extIrq1Input = st.pinSel ? st.pinBSync[1] : st.pinASync[1];

    // registered outputs straight from the state
    assign timerIrq = st.irq;
    assign rdData = st.rdData;
endmodule : rtpo_timer

// ---- logic/rtpo_map.svh ----
// register offsets, field positions, reset values and count figures
// assumes inclusion by bare name from the timer files
`ifndef RTPO_MAP_SVH
`define RTPO_MAP_SVH
`define RTPO_ADDR_W 3
`define RTPO_OFF_CTRL 3'h0
`define RTPO_OFF_PINCTL 3'h1
`define RTPO_OFF_MODE 3'h2
`define RTPO_OFF_PRESC 3'h3
`define RTPO_OFF_MAIN 3'h4
`define RTPO_OFF_SRC 3'h5
`define RTPO_CTRL_START 0
`define RTPO_CTRL_STOP 1
`define RTPO_CTRL_ACTIVE 2
`define RTPO_PIN_POL 0
`define RTPO_PIN_OFF 1
`define RTPO_PIN_INVEN 2
`define RTPO_PIN_SEL 3
`define RTPO_MODE_PULSE 0
`define RTPO_RST_BYTE 8'h00
`define RTPO_DIV2 8'h01
`define RTPO_DIV8 8'h07
`endif

// ---- logic/rtpo_pkg.sv ----
// types shared by the pulse output timer
// assumes nothing beyond a SystemVerilog compiler
package rtpo_pkg;
    typedef enum logic [2:0] {
        RTPO_SRC_F1 = 3'b000,
        RTPO_SRC_F2 = 3'b001,
        RTPO_SRC_F8 = 3'b010,
        RTPO_SRC_OSC = 3'b011,
        RTPO_SRC_SUB = 3'b100
    } rtpo_src_e;
    typedef logic [7:0] rtpo_byte_t;
endpackage : rtpo_pkg

// ---- logic/rtpo_stage.sv ----
// one down-counting stage: reload register plus counter
// assumes the parent supplies a one-cycle count event on clk
`timescale 1ns/10ps
module rtpo_stage #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic countEvt,
    input wire logic running,
    output logic [WIDTH-1:0] count,
    output logic underflow
);
    typedef struct packed {
        logic [WIDTH-1:0] reload;
        logic [WIDTH-1:0] cnt;
        logic pend;
    } rtpo_stage_s;
    rtpo_stage_s st;
    rtpo_stage_s next_st;

    // underflow on a count event while the counter sits at zero;
    // an event spent by a write neither reloads nor underflows
    assign underflow = running && countEvt && !wrEn &&
        (st.cnt == '0);
    assign count = st.cnt;

    // write, deferred reload and decrement
    always_comb begin
        next_st = st;
        if (wrEn) begin
            next_st.reload = wrData;
            if (running) begin
                next_st.pend = 1'b1;
            end else begin
                next_st.cnt = wrData;
            end
        end
        if (running && countEvt && !wrEn) begin
            if (st.pend || st.cnt == '0) begin
                next_st.cnt = st.reload;
                next_st.pend = 1'b0;
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
        if (!running && !wrEn) begin
            next_st.pend = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end
endmodule : rtpo_stage

// ---- verification/rtpo_pin_load.sv ----
// board load on the two timer pins
// assumes push-pull drive while an enable is high
`timescale 1ns/10ps
module rtpo_pin_load (
    input wire logic aOut,
    input wire logic aOe,
    input wire logic bOut,
    input wire logic bOe,
    output logic lvlA,
    output logic lvlB
);
    // a released pin floats to the pull-up level
    assign lvlA = aOe ? aOut : 1'b1;
    assign lvlB = bOe ? bOut : 1'b1;
endmodule : rtpo_pin_load

// ---- verification/rtpo_timer_checker.sv ----
// port assertions for the pulse output timer
// assumes a bind onto rtpo_timer, one clock domain
`timescale 1ns/10ps
module rtpo_timer_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdData,
    input wire logic portOeA,
    input wire logic portOeB,
    input wire logic invPortOe,
    input wire logic pinAOut,
    input wire logic pinAOe,
    input wire logic pinBOe,
    input wire logic invertedOutPin,
    input wire logic invertedOutOe,
    input wire logic timerIrq
);
    logic run, pol, off, sel, pls;
    wire wr = wrStb && clkEn;
    wire ownA = pinAOe && !portOeA;
    // shadow copy of the control bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {run, pol, off, sel, pls} <= '0;
        end else if (wr) begin
            if (addr == 3'h0) run <= wrData[0] && !wrData[1];
            if (addr == 3'h1) {sel, off, pol} <= {wrData[3], wrData[1:0]};
            if (addr == 3'h2) pls <= wrData[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ld;
        wr && addr == 3'h4 && !run ##1 !wrStb ##1 rdStb && addr == 3'h4
            |=> rdData == $past(wrData, 3);
    endproperty
    a_ld: assert property (p_ld) else $error("bad load");
    property p_stop;
        !run && !$past(run) |-> !timerIrq;
    endproperty
    a_stop: assert property (p_stop) else $error("irq stopped");
    property p_inv;
        ownA && invertedOutOe && !invPortOe |-> invertedOutPin != pinAOut;
    endproperty
    a_inv: assert property (p_inv) else $error("bad inverse");
    property p_tog;
        timerIrq && ownA && $past(ownA) && !$past(wr)
            |-> pinAOut != $past(pinAOut);
    endproperty
    a_tog: assert property (p_tog) else $error("no toggle");
    property p_mode;
        wr && addr == 3'h2 && wrData[0] ##1 !timerIrq && ownA
            |-> pinAOut == pol;
    endproperty
    a_mode: assert property (p_mode) else $error("bad start");
    property p_selA;
        pls && !off && !sel |-> pinAOe && pinBOe == portOeB;
    endproperty
    a_selA: assert property (p_selA) else $error("bad pin");
    property p_selB;
        pls && !off && sel |-> pinBOe && pinAOe == portOeA;
    endproperty
    a_selB: assert property (p_selB) else $error("bad pin");
    property p_off;
        pls && off |-> pinAOe == portOeA && pinBOe == portOeB;
    endproperty
    a_off: assert property (p_off) else $error("not off");
    c_irq: cover property (timerIrq && ownA);
    c_selB: cover property (pls && sel && !off);
    c_off: cover property (pls && off);
endmodule : rtpo_timer_checker
bind rtpo_timer rtpo_timer_checker u_chk (.*);

// ---- verification/tb.sv ----
// self-checking bench for the pulse output timer
// assumes the design, pin load and checker compile first
`timescale 1ns/10ps
module tb;
    logic clk = 0, arst_n = 0, wrStb = 0, rdStb = 0, osc = 0, sub = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wrData = 8'h00, v, rdData;
    logic pinAOut, pinAOe, pinBOut, pinBOe, lvlA, lvlB;
    logic invertedOutPin, invertedOutOe, extIrq1Input, timerIrq;
    int failCount = 0, checks = 0, n, cnt = 0;
    // period in clk cycles, source, prescale, main
    logic [31:0] rows [6] = '{32'h0100_0000, 32'h0c00_0203,
        32'h0801_0101, 32'h1802_0002, 32'h0c03_0100, 32'h1404_0001};
    rtpo_timer uut (.*, .clkEn(1'b1), .onchipOscClock(osc),
        .subclockDiv32(sub), .portOutA(osc), .portOutB(sub),
        .portOeA(1'b0), .portOeB(1'b0), .pinAIn(lvlA), .pinBIn(lvlB),
        .invPortOut(!osc), .invPortOe(1'b0));
    rtpo_pin_load load (.aOut(pinAOut), .aOe(pinAOe), .bOut(pinBOut),
        .bOe(pinBOe), .lvlA(lvlA), .lvlB(lvlB));
    always #50 clk = !clk;
    // slow sources: 6 and 10 cycles a period
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (cnt % 3 == 2) osc <= !osc;
        if (cnt % 5 == 4) sub <= !sub;
    end
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        step;
        wrStb <= 1'b0;
        step;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        addr <= a;
        rdStb <= 1'b1;
        step;
        rdStb <= 1'b0;
        v = rdData;
        step;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitIrq;
        n = 0;
        while (timerIrq !== 1'b1 && n < 3000) begin
            step;
            n++;
        end
    endtask : waitIrq
    task automatic reportAndStop;
        $display("checks %0d errors %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : reportAndStop
    // rows: source, prescale, main; period between two underflows
    initial begin
        repeat (2) @(posedge clk);
        #1 arst_n = 1;
        step;
        wr(3'h1, 8'h04);
        wr(3'h2, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, {6'h00, i[0], 1'b0});
            wr(3'h5, {5'h00, rows[i][18:16]});
            wr(3'h3, rows[i][15:8]);
            wr(3'h4, rows[i][7:0]);
            wr(3'h0, 8'h01);
            waitIrq;
            step;
            waitIrq;
            chk(8'(n + 1), rows[i][31:24]);
        end
        // stopped load, then a write while running
        wr(3'h0, 8'h02);
        wr(3'h4, 8'h5a);
        rd(3'h4);
        chk(v, 8'h5a);
        wr(3'h5, 8'h02);
        wr(3'h3, 8'hff);
        wr(3'h4, 8'h10);
        wr(3'h0, 8'h01);
        wr(3'h4, 8'h33);
        rd(3'h4);
        chk(v, 8'h10);
        rd(3'h0);
        chk({7'h00, v[2]}, 8'h01);
        wr(3'h0, 8'h03);
        rd(3'h0);
        chk({7'h00, v[2]}, 8'h00);
        // second pin, both start levels, inverse and off
        wr(3'h1, 8'h0c);
        wr(3'h2, 8'h01);
        chk({6'h00, lvlB, invertedOutPin}, 8'h01);
        repeat (3) step;
        chk({7'h00, extIrq1Input}, 8'h00);
        wr(3'h1, 8'h0d);
        wr(3'h2, 8'h01);
        chk({6'h00, lvlB, invertedOutPin}, 8'h02);
        repeat (3) step;
        chk({7'h00, extIrq1Input}, 8'h01);
        wr(3'h1, 8'h0a);
        chk({7'h00, pinBOe}, 8'h00);
        // second reset clears every register
        arst_n = 0;
        step;
        arst_n = 1;
        for (int a = 0; a < 7; a++) begin
            rd(3'(a));
            chk(v, 8'h00);
        end
        reportAndStop;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        reportAndStop;
    end
endmodule : tb
